// ---- rtl/alm_top.sv ----
// What this block does
// - A limit setting outside the channel's nominal range, other than an off code, is refused and flags a parameter error.
// - Upper limit 7FFFh switches upper supervision off and lower limit 8000h switches lower off.
// - A measured value crossing an active limit raises a process interrupt.
// - Faults raise only a diagnostics interrupt; of them only wire break is switchable.
// - Limit overflow and underflow raise a process interrupt, or a diagnostics interrupt if a record is still pending unacknowledged, each with its own enable.
// - On a CANopen coupler the record leaves in an emergency message.
// - With a CPU, PROFIBUS or PROFINET coupler the record leaves in a diagnostics message.
// - Under EtherCAT the record is at index 5000h: 02h overflow, 03h underflow, 04h/05h time.
// - The overflow byte resets to 00h, bit 0 is channel 0, bit 1 channel 1, bits 7..2 reserved.
// - The underflow byte resets to 00h and holds one lower-limit flag per channel.
// - In the underflow byte bit 0 is channel 0, bit 1 channel 1, bits 7..2 reserved.
// - A free running 32-bit microsecond counter starts at zero and wraps to zero.
// - The 16-bit timestamp is the low half of the microsecond counter in the cycle of the crossing sample, one clock before the interrupt fires.
`timescale 1ns/100ps

module alm_top
  import alm_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,

  // measured values
  input wire logic [ALM_CH-1:0][ALM_VAL_W-1:0] meas_val_i,
  input wire logic meas_vld_i,

  // nominal range of the selected measuring range
  input wire logic [ALM_CH-1:0][ALM_VAL_W-1:0] nom_min_i,
  input wire logic [ALM_CH-1:0][ALM_VAL_W-1:0] nom_max_i,

  // limit parameter write
  input wire logic param_wr_i,
  input wire logic [$clog2(ALM_CH)-1:0] param_ch_i,
  input wire alm_lim_t param_lim_i,

  // configuration
  input wire alm_cfg_t cfg_i,
  input wire alm_bus_t bus_mode_i,

  // fault events
  input wire logic [ALM_CH-1:0] wire_break_i,
  input wire logic [ALM_CH-1:0] range_ov_i,
  input wire logic [ALM_CH-1:0] range_un_i,
  input wire logic diag_buf_ov_i,
  input wire logic comm_err_i,

  // record hand-off
  input wire logic rec_ack_i,

  // object read
  input wire logic obj_rd_i,
  input wire logic [15:0] obj_index_i,
  input wire logic [7:0] obj_sub_i,

  // process interrupt record
  output logic proc_irq_o,
  output alm_msg_t msg_kind_o,
  output logic rec_pending_o,
  output logic [7:0] limit_overflow_flags_o,
  output logic [7:0] limit_underflow_flags_o,
  output logic [15:0] interrupt_timestamp_us_o,

  // diagnostics
  output logic diag_irq_o,
  output logic [7:0] diag_cause_o,
  output logic param_err_o,

  // time base
  output logic [31:0] us_count_o,

  // object read answer
  output logic [7:0] obj_rdata_o,
  output logic obj_ack_o,
  output logic obj_err_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  alm_state_t st_ff;
  alm_state_t nxt_st;

  logic [ALM_CH-1:0] ov_now;
  logic [ALM_CH-1:0] un_now;
  logic [ALM_CH-1:0] ov_ev;
  logic [ALM_CH-1:0] un_ev;
  logic [ALM_CH-1:0] up_ok;
  logic [ALM_CH-1:0] lo_ok;

  ////////////////////////////////////////////////////////////////////////////
  // per channel compare

  for (genvar c = 0; c < ALM_CH; c++) begin : g_ch
    // supervision active unless the off code is set
    assign ov_now[c] = (st_ff.upper[c] != ALM_UL_OFF) &&
                       ($signed(meas_val_i[c]) > $signed(st_ff.upper[c]));
    assign un_now[c] = (st_ff.lower[c] != ALM_LL_OFF) &&
                       ($signed(meas_val_i[c]) < $signed(st_ff.lower[c]));

    // crossing is the step from inside to beyond
    assign ov_ev[c] = meas_vld_i && ov_now[c] && !st_ff.above[c] && cfg_i.ov_en;
    assign un_ev[c] = meas_vld_i && un_now[c] && !st_ff.below[c] && cfg_i.un_en;

    // setting check against nominal range, off codes always legal
    assign up_ok[c] = (param_lim_i.upper == ALM_UL_OFF) ||
                      (($signed(param_lim_i.upper) >= $signed(nom_min_i[c])) &&
                       ($signed(param_lim_i.upper) <= $signed(nom_max_i[c])));
    assign lo_ok[c] = (param_lim_i.lower == ALM_LL_OFF) ||
                      (($signed(param_lim_i.lower) >= $signed(nom_min_i[c])) &&
                       ($signed(param_lim_i.lower) <= $signed(nom_max_i[c])));
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [7:0] dg_ev;
    logic pi_ev;
    logic pi_lost;
    logic par_bad;

    dg_ev = 8'h00;
    pi_ev = 1'b0;
    pi_lost = 1'b0;
    par_bad = 1'b0;
    nxt_st = st_ff;
    nxt_st.proc_irq = 1'b0;
    nxt_st.diag_irq = 1'b0;
    nxt_st.obj_ack = 1'b0;
    nxt_st.obj_err = 1'b0;

    // microsecond ticker, wraps naturally
    if (st_ff.div == ALM_DIV_LAST) begin
      nxt_st.div = '0;
      nxt_st.us = st_ff.us + 32'h0000_0001;
    end else begin
      nxt_st.div = st_ff.div + ALM_DIV_W'(1);
    end

    // limit parameter write
    if (param_wr_i) begin
      if (up_ok[param_ch_i] && lo_ok[param_ch_i]) begin
        nxt_st.upper[param_ch_i] = param_lim_i.upper;
        nxt_st.lower[param_ch_i] = param_lim_i.lower;
        nxt_st.param_err = 1'b0;
      end else begin
        par_bad = 1'b1;
        nxt_st.param_err = 1'b1;
      end
    end

    // beyond-limit memory for edge detection
    if (meas_vld_i) begin
      nxt_st.above = ov_now;
      nxt_st.below = un_now;
    end

    // process interrupt and record snapshot
    pi_ev = (|ov_ev) || (|un_ev);
    if (pi_ev) begin
      if ((st_ff.rec_st == ALM_REC_PENDING) && !rec_ack_i) begin
        pi_lost = 1'b1;
      end else begin
        nxt_st.rec_st = ALM_REC_PENDING;
        nxt_st.rec.ov = 8'(ov_ev);
        nxt_st.rec.un = 8'(un_ev);
        nxt_st.rec.ts = st_ff.us[15:0];
        nxt_st.proc_irq = 1'b1;
        case (bus_mode_i)
          ALM_BUS_CANOPEN: nxt_st.msg = ALM_MSG_EMERGENCY;
          ALM_BUS_CPU, ALM_BUS_PROFIBUS, ALM_BUS_PROFINET: begin
            nxt_st.msg = ALM_MSG_DIAG;
          end
          ALM_BUS_ETHERCAT: nxt_st.msg = ALM_MSG_OBJECT;
          default: nxt_st.msg = ALM_MSG_NONE;
        endcase
      end
    end else if (rec_ack_i) begin
      nxt_st.rec_st = ALM_REC_IDLE;
    end

    // diagnostics events, never a process interrupt
    dg_ev[ALM_DG_PARAM] = par_bad;
    dg_ev[ALM_DG_WIRE] = (|wire_break_i) && cfg_i.wb_en;
    dg_ev[ALM_DG_RANGE_OV] = |range_ov_i;
    dg_ev[ALM_DG_RANGE_UN] = |range_un_i;
    dg_ev[ALM_DG_BUF_OV] = diag_buf_ov_i;
    dg_ev[ALM_DG_COMM] = comm_err_i;
    dg_ev[ALM_DG_PI_LOST] = pi_lost;
    if (|dg_ev) begin
      nxt_st.diag_irq = 1'b1;
      nxt_st.cause = dg_ev;
    end

    // object read of the record
    if (obj_rd_i) begin
      nxt_st.obj_ack = 1'b1;
      nxt_st.obj_rdata = 8'h00;
      if (obj_index_i != ALM_OBJ_INDEX) begin
        nxt_st.obj_err = 1'b1;
      end else begin
        case (obj_sub_i)
          ALM_SUB_OV: nxt_st.obj_rdata = st_ff.rec.ov;
          ALM_SUB_UN: nxt_st.obj_rdata = st_ff.rec.un;
          ALM_SUB_TS_LO: nxt_st.obj_rdata = st_ff.rec.ts[7:0];
          ALM_SUB_TS_HI: nxt_st.obj_rdata = st_ff.rec.ts[15:8];
          default: nxt_st.obj_err = 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.us <= ALM_US_RST;
      st_ff.upper <= {ALM_CH{ALM_UL_OFF}};
      st_ff.lower <= {ALM_CH{ALM_LL_OFF}};
      st_ff.rec.ov <= ALM_OV_RST;
      st_ff.rec.un <= ALM_UN_RST;
      st_ff.rec.ts <= ALM_TS_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign proc_irq_o = st_ff.proc_irq;
  assign msg_kind_o = st_ff.msg;
  assign rec_pending_o = (st_ff.rec_st == ALM_REC_PENDING);
  assign limit_overflow_flags_o = st_ff.rec.ov;
  assign limit_underflow_flags_o = st_ff.rec.un;
  assign interrupt_timestamp_us_o = st_ff.rec.ts;
  assign diag_irq_o = st_ff.diag_irq;
  assign diag_cause_o = st_ff.cause;
  assign param_err_o = st_ff.param_err;
  assign us_count_o = st_ff.us;
  assign obj_rdata_o = st_ff.obj_rdata;
  assign obj_ack_o = st_ff.obj_ack;
  assign obj_err_o = st_ff.obj_err;

endmodule : alm_top

// ---- rtl/alm_pkg.sv ----
package alm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // channel count and value format
  localparam int ALM_CH = 2;
  localparam int ALM_VAL_W = 16;

  // limit settings that switch supervision off
  localparam logic [15:0] ALM_UL_OFF = 16'h7fff;
  localparam logic [15:0] ALM_LL_OFF = 16'h8000;

  ////////////////////////////////////////////////////////////////////////////
  // object access of the record
  localparam logic [15:0] ALM_OBJ_INDEX = 16'h5000;
  localparam logic [7:0] ALM_SUB_OV = 8'h02;
  localparam logic [7:0] ALM_SUB_UN = 8'h03;
  localparam logic [7:0] ALM_SUB_TS_LO = 8'h04;
  localparam logic [7:0] ALM_SUB_TS_HI = 8'h05;

  // record values after reset
  localparam logic [7:0] ALM_OV_RST = 8'h00;
  localparam logic [7:0] ALM_UN_RST = 8'h00;
  localparam logic [15:0] ALM_TS_RST = 16'h0000;
  localparam logic [31:0] ALM_US_RST = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // microsecond tick from the 10 MHz clock
  localparam int ALM_CLK_HZ = 10_000_000;
  localparam int ALM_TICK_US = 1;
  localparam int ALM_CYC_PER_US = (ALM_CLK_HZ / 1_000_000) * ALM_TICK_US;
  localparam int ALM_DIV_W = 4;
  localparam logic [ALM_DIV_W-1:0] ALM_DIV_LAST = ALM_DIV_W'(ALM_CYC_PER_US - 1);

  ////////////////////////////////////////////////////////////////////////////
  // diagnostic cause bit positions
  localparam int ALM_DG_PARAM = 0;
  localparam int ALM_DG_WIRE = 1;
  localparam int ALM_DG_RANGE_OV = 2;
  localparam int ALM_DG_RANGE_UN = 3;
  localparam int ALM_DG_BUF_OV = 4;
  localparam int ALM_DG_COMM = 5;
  localparam int ALM_DG_PI_LOST = 6;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    ALM_BUS_CPU, ALM_BUS_PROFIBUS, ALM_BUS_PROFINET, ALM_BUS_CANOPEN, ALM_BUS_ETHERCAT
  } alm_bus_t;

  typedef enum logic [1:0] {
    ALM_MSG_NONE, ALM_MSG_EMERGENCY, ALM_MSG_DIAG, ALM_MSG_OBJECT
  } alm_msg_t;

  typedef enum logic {ALM_REC_IDLE, ALM_REC_PENDING} alm_rec_state_t;

  typedef struct packed {
    logic [7:0] ov;
    logic [7:0] un;
    logic [15:0] ts;
  } alm_rec_t;

  typedef struct packed {
    logic ov_en;
    logic un_en;
    logic wb_en;
  } alm_cfg_t;

  typedef struct packed {
    logic [ALM_VAL_W-1:0] upper;
    logic [ALM_VAL_W-1:0] lower;
  } alm_lim_t;

  typedef struct packed {
    logic [ALM_DIV_W-1:0] div;
    logic [31:0] us;
    logic [ALM_CH-1:0][ALM_VAL_W-1:0] upper;
    logic [ALM_CH-1:0][ALM_VAL_W-1:0] lower;
    logic [ALM_CH-1:0] above;
    logic [ALM_CH-1:0] below;
    alm_rec_state_t rec_st;
    alm_rec_t rec;
    alm_msg_t msg;
    logic proc_irq;
    logic diag_irq;
    logic [7:0] cause;
    logic param_err;
    logic [7:0] obj_rdata;
    logic obj_ack;
    logic obj_err;
  } alm_state_t;

endpackage : alm_pkg

// ---- sim/alm_properties.sv ----
`timescale 1ns/100ps
module alm_properties
  import alm_pkg::*;
(
  // block inputs
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ALM_CH-1:0] wire_break_i,
  input wire alm_cfg_t cfg_i,
  input wire logic comm_err_i,
  input wire logic obj_rd_i,
  input wire logic [15:0] obj_index_i,
  input wire logic [7:0] obj_sub_i,
  // block outputs
  input wire logic proc_irq_o,
  input wire logic rec_pending_o,
  input wire logic [7:0] limit_overflow_flags_o,
  input wire logic [7:0] limit_underflow_flags_o,
  input wire logic [15:0] interrupt_timestamp_us_o,
  input wire logic diag_irq_o,
  input wire logic [7:0] diag_cause_o,
  input wire logic param_err_o,
  input wire logic [31:0] us_count_o,
  input wire logic [7:0] obj_rdata_o,
  input wire logic obj_ack_o,
  input wire logic obj_err_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////
  a_param_bad: assert property ($rose(param_err_o) |-> diag_irq_o && diag_cause_o[0])
    else $error("param error without diag");
  a_irq_record: assert property (proc_irq_o |-> rec_pending_o &&
    (limit_overflow_flags_o | limit_underflow_flags_o) != 8'h00) else $error("empty record");
  a_ov_reserved: assert property (limit_overflow_flags_o[7:2] == 6'h00)
    else $error("overflow reserved bits set");
  a_un_reserved: assert property (limit_underflow_flags_o[7:2] == 6'h00)
    else $error("underflow reserved bits set");
  a_us_step: assert property ($changed(us_count_o) |->
    us_count_o == $past(us_count_o) + 32'h1) else $error("us counter jump");
  a_us_period: assert property ($changed(us_count_o) |=>
    $stable(us_count_o)[*8] ##1 $stable(us_count_o) ##1 $changed(us_count_o))
    else $error("us counter period");
  a_ts_capture: assert property (proc_irq_o |->
    interrupt_timestamp_us_o == 16'($past(us_count_o))) else $error("timestamp wrong");
  a_wire_diag: assert property (wire_break_i != 2'h0 && cfg_i.wb_en |=>
    diag_irq_o && diag_cause_o[1]) else $error("wire break lost");
  a_comm_diag: assert property (comm_err_i |=> diag_irq_o && diag_cause_o[5])
    else $error("comm error lost");
  a_obj_bad: assert property (obj_rd_i && obj_index_i != ALM_OBJ_INDEX |=>
    obj_err_o && obj_ack_o && obj_rdata_o == 8'h00) else $error("bad index answered");
  a_obj_ovf: assert property (obj_rd_i && obj_index_i == ALM_OBJ_INDEX &&
    obj_sub_i == ALM_SUB_OV |=> obj_ack_o && obj_rdata_o == $past(limit_overflow_flags_o))
    else $error("overflow read wrong");
  c_proc: cover property (proc_irq_o);
  c_param: cover property ($rose(param_err_o));
  c_lost: cover property (diag_irq_o && diag_cause_o[6]);
  c_obj_err: cover property (obj_err_o);
endmodule : alm_properties

bind alm_top alm_properties i_props (.*);

// ---- sim/alm_coupler.sv ----
`timescale 1ns/100ps
module alm_coupler #(
  parameter int DLY = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // record handshake
  input wire logic pend_i,
  input wire logic stall_i,
  output logic ack_o
);
  int cnt_ff;
  // takes a pending record after a delay, never while stalled
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= 0;
      ack_o <= 1'b0;
    end else begin
      cnt_ff <= (!pend_i || stall_i || ack_o) ? 0 : cnt_ff + 1;
      ack_o <= pend_i && !stall_i && !ack_o && cnt_ff == DLY;
    end
  end
endmodule : alm_coupler

// ---- sim/alm_top_tb.sv ----
`timescale 1ns/100ps
module alm_top_tb
  import alm_pkg::*;
;
  logic clk_i, rst_i, meas_vld_i, param_wr_i, param_ch_i, diag_buf_ov_i, comm_err_i;
  logic rec_ack_i, obj_rd_i, stall, proc_irq_o, rec_pending_o, diag_irq_o, param_err_o;
  logic obj_ack_o, obj_err_o;
  logic [ALM_CH-1:0][ALM_VAL_W-1:0] meas_val_i, nom_min_i, nom_max_i;
  logic [ALM_CH-1:0] wire_break_i, range_ov_i, range_un_i;
  logic [7:0] obj_sub_i, limit_overflow_flags_o, limit_underflow_flags_o;
  logic [7:0] diag_cause_o, obj_rdata_o;
  logic [15:0] obj_index_i, interrupt_timestamp_us_o, ts_cap;
  logic [31:0] us_count_o;
  alm_lim_t param_lim_i;
  alm_cfg_t cfg_i;
  alm_bus_t bus_mode_i;
  alm_msg_t msg_kind_o;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  alm_top i_dut (.*);
  alm_coupler #(.DLY(3)) i_host (.clk_i, .rst_i, .pend_i(rec_pending_o), .stall_i(stall),
    .ack_o(rec_ack_i));
  //////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end
  //////////////////////////////////////////
  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask : step
  task automatic put_lim(input logic ch, input logic [15:0] up, input logic [15:0] lo);
    step();
    param_ch_i = ch;
    param_lim_i = '{upper: up, lower: lo};
    param_wr_i = 1'b1;
    step();
    param_wr_i = 1'b0;
  endtask : put_lim
  task automatic sample(input logic [15:0] v0, input logic [15:0] v1);
    step();
    ts_cap = us_count_o[15:0];
    meas_val_i = {v1, v0};
    meas_vld_i = 1'b1;
    step();
    meas_vld_i = 1'b0;
  endtask : sample
  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [7:0] exp);
    step();
    obj_index_i = idx;
    obj_sub_i = sub;
    obj_rd_i = 1'b1;
    step();
    obj_rd_i = 1'b0;
    chk({obj_ack_o, obj_err_o, obj_rdata_o}, {1'b1,
      !(idx == ALM_OBJ_INDEX && sub inside {[ALM_SUB_OV:ALM_SUB_TS_HI]}), exp});
  endtask : rd
  task automatic wait_idle();
    int n;
    n = 0;
    while (rec_pending_o !== 1'b0 && n < 50) begin
      step();
      n++;
    end
    chk(rec_pending_o, 1'b0);
  endtask : wait_idle
  //////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    {meas_val_i, meas_vld_i, param_wr_i, param_ch_i, param_lim_i, diag_buf_ov_i, comm_err_i,
      obj_rd_i, obj_index_i, obj_sub_i, stall, wire_break_i, range_ov_i, range_un_i} = '0;
    nom_min_i = {2{16'hfc18}};
    nom_max_i = {2{16'h03e8}};
    cfg_i = 3'b111;
    bus_mode_i = ALM_BUS_CPU;
    repeat (10) step();
    rst_i = 1'b0;
    chk({limit_overflow_flags_o, limit_underflow_flags_o}, {ALM_OV_RST, ALM_UN_RST});
    chk({interrupt_timestamp_us_o, us_count_o}, {ALM_TS_RST, ALM_US_RST});
    put_lim(1'b0, 16'h07d0, 16'hfe0c);
    chk({param_err_o, diag_irq_o, diag_cause_o}, 10'h301);
    put_lim(1'b1, ALM_UL_OFF, ALM_LL_OFF);
    chk(param_err_o, 1'b0);
    sample(16'h0000, 16'h8ad0);
    chk(proc_irq_o, 1'b0);
    put_lim(1'b0, 16'h01f4, 16'hfe0c);
    put_lim(1'b1, 16'h01f4, 16'hfe0c);
    for (int m = 0; m < 5; m++) begin
      bus_mode_i = alm_bus_t'(m);
      sample(16'h0000, 16'h0000);
      sample((m % 2) ? 16'h0000 : 16'h0258, (m % 2) ? 16'hfda8 : 16'h0000);
      chk({proc_irq_o, rec_pending_o, diag_irq_o}, 3'b110);
      chk(limit_overflow_flags_o, (m % 2) ? 8'h00 : 8'h01);
      chk(limit_underflow_flags_o, (m % 2) ? 8'h02 : 8'h00);
      chk(interrupt_timestamp_us_o, ts_cap);
      chk(msg_kind_o, m == 3 ? ALM_MSG_EMERGENCY :
        m == 4 ? ALM_MSG_OBJECT : ALM_MSG_DIAG);
      wait_idle();
    end
    rd(ALM_OBJ_INDEX, ALM_SUB_OV, 8'h01);
    rd(ALM_OBJ_INDEX, ALM_SUB_UN, 8'h00);
    rd(ALM_OBJ_INDEX, ALM_SUB_TS_LO, ts_cap[7:0]);
    rd(ALM_OBJ_INDEX, ALM_SUB_TS_HI, ts_cap[15:8]);
    rd(16'h5001, ALM_SUB_OV, 8'h00);
    rd(ALM_OBJ_INDEX, 8'h06, 8'h00);
    sample(16'h0000, 16'h0000);
    sample(16'h0258, 16'hfda8);
    chk({limit_overflow_flags_o, limit_underflow_flags_o}, 16'h0102);
    wait_idle();
    cfg_i.ov_en = 1'b0;
    sample(16'h0000, 16'h0000);
    sample(16'h0258, 16'h0000);
    chk(proc_irq_o, 1'b0);
    cfg_i.ov_en = 1'b1;
    stall = 1'b1;
    sample(16'h0000, 16'h0000);
    sample(16'h0000, 16'hfda8);
    sample(16'h0000, 16'h0000);
    sample(16'h0000, 16'hfda8);
    chk({proc_irq_o, diag_irq_o, diag_cause_o}, 10'h140);
    stall = 1'b0;
    wait_idle();
    for (int i = 0; i < 6; i++) begin
      cfg_i.wb_en = (i != 5);
      step();
      {wire_break_i[0], range_ov_i[0], range_un_i[0], diag_buf_ov_i, comm_err_i} = 5'h10 >> i % 5;
      step();
      {wire_break_i[0], range_ov_i[0], range_un_i[0], diag_buf_ov_i, comm_err_i} = 5'h00;
      chk({proc_irq_o, diag_irq_o}, {1'b0, i != 5});
      chk(diag_cause_o, (i == 5) ? 8'h20 : 8'h02 << i);
    end
    repeat (30) step();
    results();
  end
endmodule : alm_top_tb
